/* File: uart_baud_and_tx_status.sv */
/*
 transmit status flags, base clock prescaler, baud divider, break width
 and receive pin input switch of the serial unit.
 assumes a frame shifter that takes tx_load and reports shift_done, and
 a register bridge on the link that holds reg_sel until reg_ack.
*/
// Summary of operation
// - buffer-full clears on power-off, disable, move
// - buffer write sets buffer-full flag
// - busy clears on power-off, disable, idle finish
// - busy sets on move, holds while sending
// - software writes buffer only when not full
// - reinit only after busy flag clears
// - base clock is clock over two power select
// - change base select only while unpowered
// - same-value rewrites never disturb running counters
// - eight-bit counter divides base clock by k
// - bit rate is divider output halved
// - change divisor only while tx, rx disabled
// - divisor resets to 255
// - break code selects 13, 14, 15 bits
// - serial control resets to 16 hex
// - switch bits route rx pin to inputs
// - status read-only, zero reset, upper bits zero
// - power-off stops clock, resets internal state
// - transmit disable resets transmit circuit
`timescale 1ns/1ns
module uart_baud_and_tx_status (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// register port and mode bits
	uart_link_if.dev link,
	// frame shifter side
	output logic tx_load,
	output logic [7:0] tx_shifter,
	input wire logic shift_done,
	output logic base_clock,
	output logic baud_tick,
	output logic [3:0] sync_break_field,
	output logic [1:0] line_format,
	// pins
	input wire logic serial_rx_pin,
	input wire logic shared_port_pin,
	output logic timer_capture_input,
	output logic external_irq_input
);
	logic [1:0] input_sel_r;
	logic [3:0] base_sel_r;
	logic [7:0] baud_div_r;
	logic [4:0] ser_ctrl_r;
	logic [7:0] tx_holding_buffer_r;
	logic buf_full_r;
	logic busy_r;
	logic ack_r;
	logic [7:0] rdata_r;
	logic tx_load_r;
	logic [7:0] tx_shifter_r;
	logic [uart_pkg::PRESC_W-1:0] presc_r;
	logic [uart_pkg::PRESC_W-1:0] presc_mask;
	logic base_tick_r;
	logic [7:0] div_cnt_r;
	logic half_r;
	logic baud_tick_r;
	logic [2:0] sync_r [2];
	logic [1:0] filt_r;
	logic [1:0] pin_in;
	logic capture_r;
	logic irq_r;
	logic take;
	logic wr;
	logic tx_on;
	logic run;
	logic move;
	logic wrap;
	logic [7:0] rd_val;

	assign take = link.reg_sel & ~ack_r;
	assign wr = take & link.reg_wr;
	assign tx_on = link.unit_power_enable & link.transmit_enable;
	assign run = link.unit_power_enable &
		(link.transmit_enable | link.receive_enable);
	assign move = tx_on & buf_full_r & (~busy_r | shift_done);
	assign wrap = div_cnt_r >= baud_div_r - 8'h01;

	// register writes; values are only stored, nothing restarts
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			input_sel_r <= uart_pkg::RST_INPUT_SEL[1:0];
			base_sel_r <= uart_pkg::RST_BASE_CLK[3:0];
			baud_div_r <= uart_pkg::RST_BAUD_DIV;
			ser_ctrl_r <= uart_pkg::RST_SER_CTRL[4:0];
			tx_holding_buffer_r <= 8'h00;
		end else if (wr) begin
			unique case (link.reg_addr)
			uart_pkg::ADDR_INPUT_SEL: begin
				input_sel_r <= link.reg_wdata[1:0];
			end
			uart_pkg::ADDR_BASE_CLK: begin
				base_sel_r <= link.reg_wdata[3:0];
			end
			uart_pkg::ADDR_BAUD_DIV: begin
				baud_div_r <= link.reg_wdata;
			end
			uart_pkg::ADDR_SER_CTRL: begin
				ser_ctrl_r <= link.reg_wdata[4:0];
			end
			uart_pkg::ADDR_TX_BUF: begin
				tx_holding_buffer_r <= link.reg_wdata;
			end
			default: begin
			end
			endcase
		end
	end

	// read mux; unmapped and write-only addresses read zero
	always_comb begin
		rd_val = 8'h00;
		unique case (link.reg_addr)
		uart_pkg::ADDR_INPUT_SEL: begin
			rd_val = {6'h00, input_sel_r};
		end
		uart_pkg::ADDR_TX_STATUS: begin
			rd_val = {6'h00, buf_full_r, busy_r};
		end
		uart_pkg::ADDR_BASE_CLK: begin
			rd_val = {4'h0, base_sel_r};
		end
		uart_pkg::ADDR_BAUD_DIV: begin
			rd_val = baud_div_r;
		end
		uart_pkg::ADDR_SER_CTRL: begin
			rd_val = {3'h0, ser_ctrl_r};
		end
		default: begin
			rd_val = 8'h00;
		end
		endcase
	end

	// answer one cycle after the request is taken
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ack_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			ack_r <= take;
			if (take) begin
				rdata_r <= rd_val;
			end
		end
	end

	// buffer-full flag; a write in the move cycle wins
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			buf_full_r <= 1'b0;
		end else if (!tx_on) begin
			buf_full_r <= 1'b0;
		end else if (wr && link.reg_addr == uart_pkg::ADDR_TX_BUF) begin
			buf_full_r <= 1'b1;
		end else if (move) begin
			buf_full_r <= 1'b0;
		end
	end

	// shifter busy flag
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			busy_r <= 1'b0;
		end else if (!tx_on) begin
			busy_r <= 1'b0;
		end else if (move) begin
			busy_r <= 1'b1;
		end else if (shift_done) begin
			busy_r <= 1'b0;
		end
	end

	// hand the buffered byte to the shifter
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tx_load_r <= 1'b0;
			tx_shifter_r <= 8'h00;
		end else begin
			tx_load_r <= move;
			if (move) begin
				tx_shifter_r <= tx_holding_buffer_r;
			end
		end
	end

	// prescaler, stopped and cleared while unpowered
	assign presc_mask = uart_pkg::PRESC_W'(
		(12'h001 << base_sel_r) - 12'h001);
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			presc_r <= '0;
			base_tick_r <= 1'b0;
		end else if (!link.unit_power_enable) begin
			presc_r <= '0;
			base_tick_r <= 1'b0;
		end else begin
			presc_r <= presc_r + 1'b1;
			base_tick_r <= (presc_r & presc_mask) == presc_mask;
		end
	end

	// divide base clock by k, then halve for the bit rate
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt_r <= 8'h00;
			half_r <= 1'b0;
			baud_tick_r <= 1'b0;
		end else if (!run) begin
			div_cnt_r <= 8'h00;
			half_r <= 1'b0;
			baud_tick_r <= 1'b0;
		end else begin
			baud_tick_r <= base_tick_r & wrap & half_r;
			if (base_tick_r) begin
				if (wrap) begin
					div_cnt_r <= 8'h00;
					half_r <= ~half_r;
				end else begin
					div_cnt_r <= div_cnt_r + 8'h01;
				end
			end
		end
	end

	// pin synchronisers and glitch filter
	assign pin_in = {shared_port_pin, serial_rx_pin};
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pin
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					sync_r[g] <= 3'h7;
					filt_r[g] <= 1'b1;
				end else begin
					sync_r[g] <= {sync_r[g][1:0], pin_in[g]};
					if (sync_r[g][1] == sync_r[g][2]) begin
						filt_r[g] <= sync_r[g][2];
					end
				end
			end
		end
	endgenerate

	// input switch for capture and interrupt inputs
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			capture_r <= 1'b1;
			irq_r <= 1'b1;
		end else begin
			capture_r <= input_sel_r[uart_pkg::BIT_CAPTURE_FROM_RX] ?
				filt_r[0] : filt_r[1];
			irq_r <= input_sel_r[uart_pkg::BIT_IRQ_FROM_RX] ?
				filt_r[0] : filt_r[1];
		end
	end

	// break width decode; unlisted codes fall back to 13 bits
	always_comb begin
		unique case (ser_ctrl_r[uart_pkg::BRK_MSB:uart_pkg::BRK_LSB])
		uart_pkg::BRK_CODE_14: sync_break_field = uart_pkg::BRK_LEN_14;
		uart_pkg::BRK_CODE_15: sync_break_field = uart_pkg::BRK_LEN_15;
		default: sync_break_field = uart_pkg::BRK_LEN_13;
		endcase
	end

	assign link.reg_ack = ack_r;
	assign link.reg_rdata = rdata_r;
	assign link.tx_buffer_full = buf_full_r;
	assign link.tx_shifter_busy = busy_r;
	assign tx_load = tx_load_r;
	assign tx_shifter = tx_shifter_r;
	assign base_clock = base_tick_r;
	assign baud_tick = baud_tick_r;
	assign line_format = ser_ctrl_r[1:0];
	assign timer_capture_input = capture_r;
	assign external_irq_input = irq_r;
endmodule

/* File: uart_pkg.sv */
/*
 constants shared by the serial status block and its register bridge.
 assumes an 8-bit register port on the device and APB on the bridge.
*/
package uart_pkg;
	// device register addresses
	localparam logic [15:0] ADDR_INPUT_SEL = 16'hFF8C;
	localparam logic [15:0] ADDR_TX_STATUS = 16'hFF95;
	localparam logic [15:0] ADDR_BASE_CLK = 16'hFF96;
	localparam logic [15:0] ADDR_BAUD_DIV = 16'hFF97;
	localparam logic [15:0] ADDR_SER_CTRL = 16'hFF98;
	localparam logic [15:0] ADDR_TX_BUF = 16'hFF99;
	// reset values
	localparam logic [7:0] RST_INPUT_SEL = 8'h00;
	localparam logic [7:0] RST_TX_STATUS = 8'h00;
	localparam logic [7:0] RST_BASE_CLK = 8'h00;
	localparam logic [7:0] RST_BAUD_DIV = 8'hFF;
	localparam logic [7:0] RST_SER_CTRL = 8'h16;
	// writable bits per register
	localparam logic [7:0] MASK_INPUT_SEL = 8'h03;
	localparam logic [7:0] MASK_BASE_CLK = 8'h0F;
	localparam logic [7:0] MASK_SER_CTRL = 8'h1F;
	// field positions
	localparam int BIT_SHIFTER_BUSY = 0;
	localparam int BIT_BUF_FULL = 1;
	localparam int BIT_IRQ_FROM_RX = 0;
	localparam int BIT_CAPTURE_FROM_RX = 1;
	localparam int BRK_LSB = 2;
	localparam int BRK_MSB = 4;
	// break width codes and lengths
	localparam logic [2:0] BRK_CODE_13 = 3'h5;
	localparam logic [2:0] BRK_CODE_14 = 3'h6;
	localparam logic [2:0] BRK_CODE_15 = 3'h7;
	localparam logic [3:0] BRK_LEN_13 = 4'hD;
	localparam logic [3:0] BRK_LEN_14 = 4'hE;
	localparam logic [3:0] BRK_LEN_15 = 4'hF;
	// prescaler and divider
	localparam int PRESC_W = 11;
	localparam logic [3:0] PRESC_SEL_MAX = 4'hB;
	localparam logic [7:0] DIV_MIN = 8'h08;
	// bridge APB offsets
	localparam logic [11:0] APB_ADDR = 12'h000;
	localparam logic [11:0] APB_WDATA = 12'h004;
	localparam logic [11:0] APB_CTRL = 12'h008;
	localparam logic [11:0] APB_STATUS = 12'h00C;
	localparam logic [11:0] APB_RDATA = 12'h010;
	localparam logic [11:0] APB_MODE = 12'h014;
	// bridge field positions
	localparam int CTRL_WRITE = 0;
	localparam int CTRL_READ = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_ERR = 1;
	localparam int ST_BUF_FULL = 2;
	localparam int ST_SHIFTER = 3;
	localparam int ST_MODE_PEND = 4;
	localparam int MODE_POWER = 0;
	localparam int MODE_TXE = 1;
	localparam int MODE_RXE = 2;
endpackage

/* File: uart_link_if.sv */
/*
 link between the register bridge and the serial status block.
 assumes both ends run on the same clock and reset.
*/
`timescale 1ns/1ns
interface uart_link_if;
	logic reg_sel;
	logic reg_wr;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic reg_ack;
	logic unit_power_enable;
	logic transmit_enable;
	logic receive_enable;
	logic tx_buffer_full;
	logic tx_shifter_busy;
	modport dev (
		input reg_sel, reg_wr, reg_addr, reg_wdata,
		input unit_power_enable, transmit_enable, receive_enable,
		output reg_rdata, reg_ack, tx_buffer_full, tx_shifter_busy
	);
	modport ctl (
		output reg_sel, reg_wr, reg_addr, reg_wdata,
		output unit_power_enable, transmit_enable, receive_enable,
		input reg_rdata, reg_ack, tx_buffer_full, tx_shifter_busy
	);
endinterface

/* File: uart_reg_bridge.sv */
/*
 APB register bridge that drives the serial unit's register port and
 mode bits, keeping the software ordering that the unit relies on.
 assumes the device answers with reg_ack while reg_sel is held.
*/
`timescale 1ns/1ns
module uart_reg_bridge (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device link
	uart_link_if.ctl link
);
	typedef enum logic [1:0] {IDLE, ROOM, ACCESS} state_e;
	state_e state_r;
	logic [15:0] addr_r;
	logic [7:0] wdata_r;
	logic [7:0] rdata_r;
	logic wr_r;
	logic err_r;
	logic [2:0] mode_r;
	logic [2:0] mode_want_r;
	logic access;
	logic ctrl_wr;
	logic start;
	logic refuse;
	logic mapped;
	logic tx_idle;

	assign access = psel & penable;
	assign ctrl_wr = access & pwrite & paddr == uart_pkg::APB_CTRL;
	assign start = ctrl_wr & (pwdata[uart_pkg::CTRL_WRITE] |
		pwdata[uart_pkg::CTRL_READ]);
	assign tx_idle = ~link.tx_buffer_full & ~link.tx_shifter_busy;
	// refuse clock and divisor changes while running
	always_comb begin
		refuse = 1'b0;
		if (state_r != IDLE) begin
			refuse = 1'b1;
		end else if (pwdata[uart_pkg::CTRL_WRITE]) begin
			if (addr_r == uart_pkg::ADDR_BASE_CLK) begin
				refuse = mode_r[uart_pkg::MODE_POWER];
			end else if (addr_r == uart_pkg::ADDR_BAUD_DIV) begin
				refuse = mode_r[uart_pkg::MODE_TXE] |
					mode_r[uart_pkg::MODE_RXE];
			end
		end
	end

	// command sequencer
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= IDLE;
			wr_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			unique case (state_r)
			IDLE: begin
				if (start && !refuse) begin
					wr_r <= pwdata[uart_pkg::CTRL_WRITE];
					if (pwdata[uart_pkg::CTRL_WRITE] &&
						addr_r == uart_pkg::ADDR_TX_BUF) begin
						state_r <= ROOM;
					end else begin
						state_r <= ACCESS;
					end
				end
			end
			ROOM: begin
				if (!link.tx_buffer_full) begin
					state_r <= ACCESS;
				end
			end
			ACCESS: begin
				if (link.reg_ack) begin
					state_r <= IDLE;
					if (!wr_r) begin
						rdata_r <= link.reg_rdata;
					end
				end
			end
			endcase
		end
	end

	// software registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			addr_r <= 16'h0000;
			wdata_r <= 8'h00;
			mode_want_r <= 3'h0;
		end else if (access && pwrite && state_r == IDLE) begin
			if (paddr == uart_pkg::APB_ADDR) begin
				addr_r <= pwdata[15:0];
			end
			if (paddr == uart_pkg::APB_WDATA) begin
				wdata_r <= pwdata[7:0];
			end
			if (paddr == uart_pkg::APB_MODE) begin
				mode_want_r <= pwdata[2:0];
			end
		end
	end

	// mode bits; dropping transmit waits for the shifter to drain
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mode_r <= 3'h0;
		end else if (mode_want_r[uart_pkg::MODE_TXE] ||
			!mode_r[uart_pkg::MODE_TXE] || tx_idle) begin
			mode_r <= mode_want_r;
		end
	end

	// error flag; a new refusal wins over a clear
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			err_r <= 1'b0;
		end else if (start && refuse) begin
			err_r <= 1'b1;
		end else if (access && pwrite && paddr == uart_pkg::APB_STATUS &&
			pwdata[uart_pkg::ST_ERR]) begin
			err_r <= 1'b0;
		end
	end

	always_comb begin
		prdata = 32'h0000_0000;
		mapped = 1'b1;
		unique case (paddr)
		uart_pkg::APB_ADDR: prdata = {16'h0000, addr_r};
		uart_pkg::APB_WDATA: prdata = {24'h00_0000, wdata_r};
		uart_pkg::APB_CTRL: prdata = 32'h0000_0000;
		uart_pkg::APB_STATUS: prdata = {27'h000_0000,
			mode_r != mode_want_r, link.tx_shifter_busy,
			link.tx_buffer_full, err_r, state_r != IDLE};
		uart_pkg::APB_RDATA: prdata = {24'h00_0000, rdata_r};
		uart_pkg::APB_MODE: prdata = {29'h0000_0000, mode_r};
		default: mapped = 1'b0;
		endcase
	end

	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign link.reg_sel = state_r == ACCESS;
	assign link.reg_wr = wr_r;
	assign link.reg_addr = addr_r;
	assign link.reg_wdata = wdata_r;
	assign link.unit_power_enable = mode_r[uart_pkg::MODE_POWER];
	assign link.transmit_enable = mode_r[uart_pkg::MODE_TXE];
	assign link.receive_enable = mode_r[uart_pkg::MODE_RXE];
endmodule

/* File: uart_link_assertions.sv */
/*
 concurrent checks on the link between register bridge and status block.
 assumes one clock and an active low asynchronous reset for both ends.
*/
`timescale 1ns/1ns
module uart_link_assertions (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// register port
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_ack,
	// mode bits and flags
	input wire logic unit_power_enable,
	input wire logic transmit_enable,
	input wire logic receive_enable,
	input wire logic tx_buffer_full,
	input wire logic tx_shifter_busy
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	logic take;
	logic buf_wr;
	logic tx_on;
	assign take = reg_sel && !reg_ack;
	assign buf_wr = take && reg_wr && reg_addr == uart_pkg::ADDR_TX_BUF;
	assign tx_on = unit_power_enable && transmit_enable;
	sequence s_take;
		reg_sel && !reg_ack;
	endsequence
	sequence s_answer;
		reg_ack ##1 !reg_ack;
	endsequence
	AST_ACK_AFTER_TAKE: assert property (s_take |=> s_answer)
		else $error("no single ack after request");
	AST_ACK_CAUSE: assert property (reg_ack |-> $past(take))
		else $error("ack without request");
	AST_SEL_HELD: assert property (take |=> reg_sel && $stable(reg_addr)
		&& $stable(reg_wdata) && $stable(reg_wr))
		else $error("request dropped before ack");
	AST_FULL_ON_WRITE: assert property (buf_wr && tx_on |=> tx_buffer_full)
		else $error("buffer write did not set full");
	AST_FULL_CAUSE: assert property ($rose(tx_buffer_full) |-> $past(buf_wr))
		else $error("full rose without write");
	AST_MOVE: assert property (tx_buffer_full && !tx_shifter_busy && tx_on
		&& !buf_wr |=> !tx_buffer_full && tx_shifter_busy)
		else $error("byte not moved to shifter");
	AST_BUSY_CAUSE: assert property ($rose(tx_shifter_busy)
		|-> $past(tx_buffer_full))
		else $error("busy rose without buffered byte");
	AST_OFF_CLEARS: assert property (!tx_on
		|=> !tx_buffer_full && !tx_shifter_busy)
		else $error("flags not cleared when off");
	AST_STATUS_READ: assert property (take && !reg_wr
		&& reg_addr == uart_pkg::ADDR_TX_STATUS |=> reg_rdata ==
		{6'h00, $past(tx_buffer_full), $past(tx_shifter_busy)})
		else $error("status read value wrong");
endmodule

/* File: tb_top.sv */
/*
 testbench driving the register bridge over apb and the status block pins.
 assumes the link interface joins both ends on one clock.
*/
`timescale 1ns/1ns
module tb_top;
	logic clock, rst_b, psel, penable, pwrite, pready, pslverr, shift_done;
	logic rx_pin, port_pin, tx_load, base_clock, baud_tick, tcap, eirq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [7:0] tx_shifter, q, b, b2;
	logic [3:0] brk;
	logic [1:0] fmt;
	logic last_err;
	int n_errors, checked, sel, k, n, n_loads;
	logic [15:0] ra[5] = '{16'hFF8C, 16'hFF95, 16'hFF96, 16'hFF97, 16'hFF98};
	logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h16};
	logic [7:0] rm[5] = '{8'h03, 8'h00, 8'h0F, 8'hFF, 8'h1F};
	uart_link_if link();
	uart_baud_and_tx_status u_uart_baud_and_tx_status (.clock(clock),
		.rst_b(rst_b), .link(link.dev), .tx_load(tx_load),
		.tx_shifter(tx_shifter), .shift_done(shift_done),
		.base_clock(base_clock), .baud_tick(baud_tick),
		.sync_break_field(brk), .line_format(fmt), .serial_rx_pin(rx_pin),
		.shared_port_pin(port_pin), .timer_capture_input(tcap),
		.external_irq_input(eirq));
	uart_reg_bridge u_uart_reg_bridge (.clock(clock), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link.ctl));
	uart_link_assertions u_uart_link_assertions (.clock(clock), .rst_b(rst_b),
		.reg_sel(link.reg_sel), .reg_wr(link.reg_wr),
		.reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack),
		.unit_power_enable(link.unit_power_enable),
		.transmit_enable(link.transmit_enable),
		.receive_enable(link.receive_enable),
		.tx_buffer_full(link.tx_buffer_full),
		.tx_shifter_busy(link.tx_shifter_busy));
	always #5 clock = ~clock;
	// count load pulses handed to the shifter
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			n_loads <= 0;
		else if (tx_load === 1'h1)
			n_loads <= n_loads + 1;
	end
	function automatic int baud_cycles(input int kk, input int ss);
		return (2 * kk) << ss;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] s);
		@(posedge clock);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock); while (pready !== 1'h1);
		s = prdata;
		last_err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic dev(input logic w, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] v);
		logic [31:0] s;
		int i;
		apb(1'h1, uart_pkg::APB_ADDR, {16'h0000, a}, s);
		apb(1'h1, uart_pkg::APB_WDATA, {24'h000000, d}, s);
		apb(1'h1, uart_pkg::APB_CTRL, w ? 32'h00000001 : 32'h00000002, s);
		i = 0;
		do begin
			apb(1'h0, uart_pkg::APB_STATUS, 32'h0, s);
			i++;
		end while (s[uart_pkg::ST_BUSY] !== 1'h0 && i < 50);
		if (s[uart_pkg::ST_BUSY] !== 1'h0)
			n_errors++;
		apb(1'h0, uart_pkg::APB_RDATA, 32'h0, s);
		v = s[7:0];
	endtask
	task automatic meas(input logic base, output int cnt);
		int i;
		i = 0;
		@(negedge clock);
		while ((base ? base_clock : baud_tick) !== 1'h1 && i < 9000) begin
			@(negedge clock);
			i++;
		end
		cnt = 0;
		do begin
			@(negedge clock);
			cnt++;
		end while ((base ? base_clock : baud_tick) !== 1'h1 && cnt < 9000);
	endtask
	task automatic pulse();
		@(posedge clock);
		shift_done <= 1'h1;
		@(posedge clock);
		shift_done <= 1'h0;
		@(negedge clock);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#300000;
		n_errors++;
		give_verdict();
	end
	initial begin
		clock = 0;
		rst_b = 0;
		{psel, penable, pwrite, shift_done} = 4'h0;
		{paddr, pwdata} = 44'h0;
		{rx_pin, port_pin} = 2'h3;
		n_errors = 0;
		checked = 0;
		r = $urandom(51);
		repeat (4) @(posedge clock);
		rst_b <= 1'h1;
		// reset values, then fixed-zero bits
		for (int i = 0; i < 5; i++) begin
			dev(1'h0, ra[i], 8'h00, q);
			chk(q, rv[i]);
			dev(1'h1, ra[i], 8'hFF, q);
			dev(1'h0, ra[i], 8'h00, q);
			chk(q, rm[i]);
		end
		dev(1'h0, 16'hFF00, 8'h00, q);
		chk(q, 8'h00);
		apb(1'h0, 12'h020, 32'h0, r);
		chk(last_err, 1'h1);
		// break width codes
		for (int c = 5; c < 8; c++) begin
			dev(1'h1, uart_pkg::ADDR_SER_CTRL, 8'(c * 4 + 2), q);
			@(negedge clock);
			chk(brk, c + 8);
			chk(fmt, 2'h2);
		end
		// input switch
		for (int i = 0; i < 4; i++) begin
			dev(1'h1, uart_pkg::ADDR_INPUT_SEL, 8'(i), q);
			b = 8'($urandom);
			rx_pin <= b[0];
			port_pin <= ~b[0];
			repeat (10) @(posedge clock);
			chk(tcap, i[1] ? b[0] : !b[0]);
			chk(eirq, i[0] ? b[0] : !b[0]);
		end
		// prescaler and divider
		for (int t = 0; t < 4; t++) begin
			sel = (t == 0) ? 0 : $urandom % 4;
			k = (t == 0) ? 8 : 8 + $urandom % 13;
			apb(1'h1, uart_pkg::APB_MODE, 32'h0, r);
			dev(1'h1, uart_pkg::ADDR_BASE_CLK, 8'(sel), q);
			dev(1'h1, uart_pkg::ADDR_BAUD_DIV, 8'(k), q);
			apb(1'h1, uart_pkg::APB_MODE, 32'h00000003, r);
			meas(1'h1, n);
			chk(n, 1 << sel);
			meas(1'h0, n);
			chk(n, baud_cycles(k, sel));
			dev(1'h1, uart_pkg::ADDR_SER_CTRL, 8'h1E, q);
			meas(1'h0, n);
			chk(n, baud_cycles(k, sel));
			dev(1'h1, uart_pkg::ADDR_BAUD_DIV, 8'hFF, q);
			dev(1'h0, uart_pkg::ADDR_BAUD_DIV, 8'h00, q);
			chk(q, k);
			dev(1'h1, uart_pkg::ADDR_BASE_CLK, 8'h0B, q);
			dev(1'h0, uart_pkg::ADDR_BASE_CLK, 8'h00, q);
			chk(q, sel);
		end
		// transmit flags
		b = 8'($urandom);
		b2 = 8'($urandom);
		dev(1'h1, uart_pkg::ADDR_TX_BUF, b, q);
		@(negedge clock);
		chk({link.tx_buffer_full, link.tx_shifter_busy}, 2'h1);
		chk(tx_shifter, b);
		chk(n_loads, 1);
		dev(1'h1, uart_pkg::ADDR_TX_BUF, b2, q);
		chk({link.tx_buffer_full, link.tx_shifter_busy}, 2'h3);
		dev(1'h0, uart_pkg::ADDR_TX_STATUS, 8'h00, q);
		chk(q, 8'h03);
		pulse();
		chk({link.tx_buffer_full, link.tx_shifter_busy}, 2'h1);
		chk(tx_shifter, b2);
		pulse();
		chk({link.tx_buffer_full, link.tx_shifter_busy}, 2'h0);
		chk(n_loads, 2);
		give_verdict();
	end
endmodule
